// ==== verilog/osd_ctrl_pkg.sv ====
// Constants for the on-screen-display output and position control block.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
package osd_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_LINES = 12;
   localparam int NUM_AREAS = 2;
   localparam int POS_W = 9;
   localparam int HCNT_W = 10;
   localparam int ROW_W = 6;
   localparam int IDX_W = 4;
   localparam int DIV_W = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_PORT_SELECT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_MISC = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_CODE_HSTART = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PLANE_COLOUR = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_LINE_VSTART = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_AREA = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_LINE_SIZE = 8'h30;
   localparam int LINES_PER_SIZE_REG = 4;
   localparam int AREA_STRIDE = 4;
   localparam int AREA_HSTART = 0;
   localparam int AREA_HSTOP = 1;
   localparam int AREA_VSTART = 2;
   localparam int AREA_VSTOP = 3;

   // Field positions
   localparam int PSEL_INTENSITY_BIT = 3;
   localparam int PSEL_SHARED_BIT = 2;
   localparam int PSEL_COLOUR_LSB = 4;
   localparam int POL_BLANK_BIT = 3;
   localparam int POL_LUMA_BIT = 2;
   localparam int POL_COLOUR_BIT = 1;
   localparam int POL_INTENSITY_BIT = 0;
   localparam int MISC_SCAN_BIT = 7;
   localparam int MISC_FUNC_BIT = 6;
   localparam int MISC_EXTENDED_BLANK_BIT = 5;
   localparam int MISC_RASTER_EN_BIT = 4;
   localparam int MISC_AREA1_LEVEL_BIT = 2;
   localparam int MISC_AREA2_LEVEL_BIT = 1;
   localparam int MISC_RASTER_LEVEL_BIT = 0;
   localparam int CTRL_TRANSFER_BIT = 0;
   localparam int CTRL_LINE_ACTIVE_BIT = 1;
   localparam int COLOUR_AREA1_LSB = 0;
   localparam int COLOUR_AREA2_LSB = 3;
   localparam int COLOUR_RASTER_LSB = 6;

   // Size field encodings and line heights in vertical counter units
   localparam logic [1:0] SIZE_SMALL = 2'h3;
   localparam logic [1:0] SIZE_MIDDLE = 2'h2;
   localparam logic [1:0] SIZE_LARGE = 2'h1;
   localparam logic [1:0] SIZE_OFF = 2'h0;
   localparam logic [ROW_W-1:0] HEIGHT_SMALL = 6'h09;
   localparam logic [ROW_W-1:0] HEIGHT_MIDDLE = 6'h12;
   localparam logic [ROW_W-1:0] HEIGHT_LARGE = 6'h24;

   // Timing: code start offset in oscillator ticks, clock cycles per tick
   localparam logic [HCNT_W-1:0] CODE_HSTART_OFFSET = 10'h014;
   localparam logic [DIV_W-1:0] OSC_DIV = 4'h3;

   // Reset values
   localparam logic [7:0] RST_PORT_SELECT = 8'hf8;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [POS_W-1:0] RST_POS = 9'h000;
   localparam logic [1:0] RST_SIZE = SIZE_OFF;
endpackage : osd_ctrl_pkg

// ==== verilog/osd_area_window.sv ====
// Decides whether the scan position lies inside one area plane.
// Assumes the horizontal count is in oscillator ticks and vertical in HD periods.
`timescale 1ns/10ps
module osd_area_window (
   // Scan position
   input wire logic [osd_ctrl_pkg::HCNT_W-1:0] hcount_in,
   input wire logic [osd_ctrl_pkg::POS_W-1:0] vcount_in,
   // Active window limits
   input wire logic [osd_ctrl_pkg::POS_W-1:0] hstart_in,
   input wire logic [osd_ctrl_pkg::POS_W-1:0] hstop_in,
   input wire logic [osd_ctrl_pkg::POS_W-1:0] vstart_in,
   input wire logic [osd_ctrl_pkg::POS_W-1:0] vstop_in,
   // Result
   output logic inside_out
);
   logic h_inside;
   logic v_inside;

   // Horizontal limits step in two ticks
   assign h_inside = (hcount_in >= {hstart_in, 1'b0}) && (hcount_in < {hstop_in, 1'b0});
   // Vertical limits step in one HD period
   assign v_inside = (vcount_in >= vstart_in) && (vcount_in < vstop_in);
   assign inside_out = h_inside & v_inside;
endmodule : osd_area_window

// ==== verilog/osd_output_position_ctrl.sv ====
// Output, polarity and position control for the on-screen display.
// Assumes HD and VD pulses and the character engine's dot data are synchronous
// to clock_in; the engine consumes line index, size, row and code start.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module osd_output_position_ctrl (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Register port
   input wire logic [osd_ctrl_pkg::ADDR_W-1:0] addr_in,
   input wire logic [osd_ctrl_pkg::DATA_W-1:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [osd_ctrl_pkg::DATA_W-1:0] rdata_out,
   // Sync pulses from the signal processor
   input wire logic horizontal_pulse_in,
   input wire logic vertical_pulse_in,
   // Code plane dot data from the character engine
   input wire logic char_dot_in,
   input wire logic fringe_dot_in,
   input wire logic char_cell_in,
   input wire logic blank_code_in,
   input wire logic code_r_in,
   input wire logic code_g_in,
   input wire logic code_b_in,
   input wire logic code_i_in,
   // General port values: 0 intensity, 1 R, 2 G, 3 B, 4 Y/BL
   input wire logic [4:0] port_value_in,
   // Pins
   output logic intensity_pin_out,
   output logic r_pin_out,
   output logic g_pin_out,
   output logic b_pin_out,
   output logic key_blank_output_out,
   // Position information to the character engine
   output logic osd_tick_out,
   output logic code_start_out,
   output logic line_active_out,
   output logic [osd_ctrl_pkg::IDX_W-1:0] line_index_out,
   output logic [1:0] line_size_out,
   output logic [osd_ctrl_pkg::ROW_W-1:0] line_row_out,
   output logic transfer_pulse_out
);
   localparam int NL = osd_ctrl_pkg::NUM_LINES;
   localparam int NA = osd_ctrl_pkg::NUM_AREAS;
   localparam int PW = osd_ctrl_pkg::POS_W;

   typedef struct packed {
      logic [7:0] port_select;
      logic [7:0] polarity;
      logic [7:0] misc;
      logic [8:0] plane_colour;
      logic [7:0] hstart_s;
      logic [7:0] hstart_a;
      logic [NL-1:0][PW-1:0] vstart_s;
      logic [NL-1:0][PW-1:0] vstart_a;
      logic [NL-1:0][1:0] size_s;
      logic [NL-1:0][1:0] size_a;
      logic [NA-1:0][3:0][PW-1:0] area_s;
      logic [NA-1:0][3:0][PW-1:0] area_a;
      logic pending;
      logic [osd_ctrl_pkg::DIV_W-1:0] div_cnt;
      logic osc_tick;
      logic hd_prev;
      logic vd_prev;
      logic [osd_ctrl_pkg::HCNT_W-1:0] hcount;
      logic [PW-1:0] vcount;
      logic [PW-1:0] scan;
      logic scan_half;
      logic in_line;
      logic [osd_ctrl_pkg::IDX_W-1:0] line_idx;
      logic [1:0] cur_size;
      logic [osd_ctrl_pkg::ROW_W-1:0] row;
      logic code_start;
      logic transfer_pulse;
      logic [osd_ctrl_pkg::DATA_W-1:0] rdata;
      logic [4:0] pins;
   } state_t;

   state_t q;
   state_t d;
   logic hd_rise;
   logic vd_rise;
   logic scan_adv;
   logic [PW-1:0] scan_next;
   logic [NL-1:0] line_hit;
   logic [NA-1:0] area_in;

   // Line height by size; an off line keeps small height
   function automatic logic [osd_ctrl_pkg::ROW_W-1:0] line_height(input logic [1:0] sz);
      case (sz)
         osd_ctrl_pkg::SIZE_MIDDLE: line_height = osd_ctrl_pkg::HEIGHT_MIDDLE;
         osd_ctrl_pkg::SIZE_LARGE: line_height = osd_ctrl_pkg::HEIGHT_LARGE;
         default: line_height = osd_ctrl_pkg::HEIGHT_SMALL;
      endcase
   endfunction : line_height

   // Edges of the sync pulses and vertical counter step
   assign hd_rise = horizontal_pulse_in & ~q.hd_prev;
   assign vd_rise = vertical_pulse_in & ~q.vd_prev;
   assign scan_adv = ~q.misc[osd_ctrl_pkg::MISC_SCAN_BIT] | q.scan_half;
   assign scan_next = scan_adv ? q.scan + 9'h001 : q.scan;

   // Per-line start match and per-area window
   generate
      for (genvar i = 0; i < NL; i++) begin : g_line
         assign line_hit[i] = (q.vstart_a[i] == scan_next);
      end
      for (genvar a = 0; a < NA; a++) begin : g_area
         osd_area_window u_window (
            .hcount_in(q.hcount),
            .vcount_in(q.vcount),
            .hstart_in(q.area_a[a][osd_ctrl_pkg::AREA_HSTART]),
            .hstop_in(q.area_a[a][osd_ctrl_pkg::AREA_HSTOP]),
            .vstart_in(q.area_a[a][osd_ctrl_pkg::AREA_VSTART]),
            .vstop_in(q.area_a[a][osd_ctrl_pkg::AREA_VSTOP]),
            .inside_out(area_in[a])
         );
      end
   endgenerate

   // Next-state logic
   always_comb begin
      logic line_end;
      logic any_hit;
      logic [osd_ctrl_pkg::IDX_W-1:0] hit_idx;
      logic [osd_ctrl_pkg::HCNT_W-1:0] code_pos;
      logic [osd_ctrl_pkg::ADDR_W-1:0] rel;
      logic code_on;
      logic raster_on;
      logic [2:0] plane_rgb;
      logic plane_i;
      logic osd_r;
      logic osd_g;
      logic osd_b;
      logic osd_i;
      logic luma;
      logic blank;
      logic shared;
      logic [4:0] osd_sig;
      line_end = 1'b0;
      any_hit = 1'b0;
      hit_idx = '0;
      code_pos = '0;
      rel = '0;
      code_on = 1'b0;
      raster_on = 1'b0;
      plane_rgb = '0;
      plane_i = 1'b0;
      osd_r = 1'b0;
      osd_g = 1'b0;
      osd_b = 1'b0;
      osd_i = 1'b0;
      luma = 1'b0;
      blank = 1'b0;
      shared = 1'b0;
      osd_sig = '0;
      d = q;
      d.osc_tick = 1'b0;
      d.code_start = 1'b0;
      d.transfer_pulse = 1'b0;
      d.hd_prev = horizontal_pulse_in;
      d.vd_prev = vertical_pulse_in;

      // Oscillator tick divider
      if (q.div_cnt == osd_ctrl_pkg::OSC_DIV - 4'h1) begin
         d.div_cnt = '0;
         d.osc_tick = 1'b1;
      end else begin
         d.div_cnt = q.div_cnt + 4'h1;
      end

      // Horizontal tick count and code line start
      code_pos = {1'b0, q.hstart_a, 1'b0} + osd_ctrl_pkg::CODE_HSTART_OFFSET;
      if (hd_rise) begin
         d.hcount = '0;
      end else if (q.osc_tick && (q.hcount != '1)) begin
         d.hcount = q.hcount + 10'h001;
      end
      if (q.osc_tick && (q.hcount == code_pos) && q.in_line) begin
         d.code_start = 1'b1;
      end

      // Lowest-numbered matching line wins
      for (int i = NL - 1; i >= 0; i--) begin
         if (line_hit[i]) begin
            any_hit = 1'b1;
            hit_idx = 4'(i);
         end
      end

      // Vertical counting and line tracking on HD rise
      line_end = q.in_line && scan_adv && ((q.row + 6'h01) == line_height(q.cur_size));
      if (vd_rise) begin
         d.vcount = '0;
         d.scan = '0;
         d.scan_half = 1'b0;
         d.in_line = 1'b0;
         d.row = '0;
      end else if (hd_rise) begin
         if (q.vcount != '1) begin
            d.vcount = q.vcount + 9'h001;
         end
         d.scan = scan_next;
         d.scan_half = q.misc[osd_ctrl_pkg::MISC_SCAN_BIT] & ~q.scan_half;
         if (q.in_line && scan_adv) begin
            d.row = q.row + 6'h01;
         end
         if (line_end) begin
            d.in_line = 1'b0;
         end
         // A line starting inside another is suppressed
         if ((!q.in_line || line_end) && scan_adv && any_hit) begin
            d.in_line = 1'b1;
            d.line_idx = hit_idx;
            d.cur_size = q.size_a[hit_idx];
            d.row = '0;
         end
      end

      // Staged values move to the display side on an allowed HD rise
      if (hd_rise && q.pending && (!q.in_line || line_end)) begin
         d.hstart_a = q.hstart_s;
         d.vstart_a = q.vstart_s;
         d.size_a = q.size_s;
         d.area_a = q.area_s;
         d.pending = 1'b0;
         d.transfer_pulse = 1'b1;
      end

      // Register writes, accepted whether or not a transfer is pending
      if (write_in) begin
         rel = addr_in - osd_ctrl_pkg::OFS_LINE_VSTART;
         case (addr_in)
            osd_ctrl_pkg::OFS_PORT_SELECT: d.port_select = wdata_in[7:0];
            osd_ctrl_pkg::OFS_POLARITY: d.polarity = wdata_in[7:0];
            osd_ctrl_pkg::OFS_MISC: d.misc = wdata_in[7:0];
            osd_ctrl_pkg::OFS_CODE_HSTART: d.hstart_s = wdata_in[7:0];
            osd_ctrl_pkg::OFS_PLANE_COLOUR: d.plane_colour = wdata_in[8:0];
            osd_ctrl_pkg::OFS_CONTROL: begin
               // Set wins over a transfer in the same cycle
               if (wdata_in[osd_ctrl_pkg::CTRL_TRANSFER_BIT]) begin
                  d.pending = 1'b1;
               end
            end
            default: begin
               if (rel < 8'(NL)) begin
                  d.vstart_s[rel[3:0]] = wdata_in[8:0];
               end
            end
         endcase
         for (int i = 0; i < NL; i++) begin
            if (addr_in == osd_ctrl_pkg::OFS_LINE_SIZE + 8'(i / 4)) begin
               d.size_s[i] = wdata_in[2*(i%4) +: 2];
            end
         end
         for (int a = 0; a < NA; a++) begin
            for (int k = 0; k < osd_ctrl_pkg::AREA_STRIDE; k++) begin
               if (addr_in == osd_ctrl_pkg::OFS_AREA + 8'(a * osd_ctrl_pkg::AREA_STRIDE + k)) begin
                  d.area_s[a][k] = wdata_in[8:0];
               end
            end
         end
      end

      // Read data, one cycle after the strobe; unmapped reads as zero
      d.rdata = '0;
      if (read_in) begin
         rel = addr_in - osd_ctrl_pkg::OFS_LINE_VSTART;
         case (addr_in)
            osd_ctrl_pkg::OFS_PORT_SELECT: d.rdata = {8'h00, q.port_select};
            osd_ctrl_pkg::OFS_POLARITY: d.rdata = {8'h00, q.polarity};
            osd_ctrl_pkg::OFS_MISC: d.rdata = {8'h00, q.misc};
            osd_ctrl_pkg::OFS_CODE_HSTART: d.rdata = {8'h00, q.hstart_s};
            osd_ctrl_pkg::OFS_PLANE_COLOUR: d.rdata = {7'h00, q.plane_colour};
            osd_ctrl_pkg::OFS_CONTROL: begin
               d.rdata[osd_ctrl_pkg::CTRL_TRANSFER_BIT] = q.pending;
               d.rdata[osd_ctrl_pkg::CTRL_LINE_ACTIVE_BIT] = q.in_line;
            end
            default: begin
               if (rel < 8'(NL)) begin
                  d.rdata = {7'h00, q.vstart_s[rel[3:0]]};
               end
            end
         endcase
         for (int i = 0; i < NL; i++) begin
            if (addr_in == osd_ctrl_pkg::OFS_LINE_SIZE + 8'(i / 4)) begin
               d.rdata[2*(i%4) +: 2] = q.size_s[i];
            end
         end
         for (int a = 0; a < NA; a++) begin
            for (int k = 0; k < osd_ctrl_pkg::AREA_STRIDE; k++) begin
               if (addr_in == osd_ctrl_pkg::OFS_AREA + 8'(a * osd_ctrl_pkg::AREA_STRIDE + k)) begin
                  d.rdata = {7'h00, q.area_s[a][k]};
               end
            end
         end
      end

      // Plane priority: code, area 1, area 2, raster
      code_on = q.in_line && (q.cur_size != osd_ctrl_pkg::SIZE_OFF) &&
         (char_dot_in | fringe_dot_in);
      raster_on = q.misc[osd_ctrl_pkg::MISC_RASTER_EN_BIT];
      if (area_in[0]) begin
         plane_rgb = q.plane_colour[osd_ctrl_pkg::COLOUR_AREA1_LSB +: 3];
         plane_i = q.misc[osd_ctrl_pkg::MISC_AREA1_LEVEL_BIT];
      end else if (area_in[1]) begin
         plane_rgb = q.plane_colour[osd_ctrl_pkg::COLOUR_AREA2_LSB +: 3];
         plane_i = q.misc[osd_ctrl_pkg::MISC_AREA2_LEVEL_BIT];
      end else if (raster_on) begin
         plane_rgb = q.plane_colour[osd_ctrl_pkg::COLOUR_RASTER_LSB +: 3];
         plane_i = q.misc[osd_ctrl_pkg::MISC_RASTER_LEVEL_BIT];
      end
      if (code_on) begin
         osd_r = code_r_in;
         osd_g = code_g_in;
         osd_b = code_b_in;
         osd_i = code_i_in;
      end else begin
         {osd_r, osd_g, osd_b} = plane_rgb;
         osd_i = plane_i;
      end
      // Intensity function: pin carries plane half-tone, character intensity ignored
      if (q.misc[osd_ctrl_pkg::MISC_FUNC_BIT] && !q.port_select[osd_ctrl_pkg::PSEL_INTENSITY_BIT]) begin
         osd_i = code_on ? 1'b0 : plane_i;
      end

      // Y and BL generation
      luma = osd_r | osd_g | osd_b | code_on | (|area_in);
      if (q.misc[osd_ctrl_pkg::MISC_EXTENDED_BLANK_BIT]) begin
         blank = 1'b1;
      end else begin
         blank = q.in_line && (q.cur_size != osd_ctrl_pkg::SIZE_OFF) &&
            char_cell_in && !blank_code_in;
      end
      if (q.port_select[osd_ctrl_pkg::PSEL_SHARED_BIT]) begin
         shared = blank ^ q.polarity[osd_ctrl_pkg::POL_BLANK_BIT];
      end else begin
         shared = luma ^ q.polarity[osd_ctrl_pkg::POL_LUMA_BIT];
      end
      osd_sig[0] = osd_i ^ q.polarity[osd_ctrl_pkg::POL_INTENSITY_BIT];
      osd_sig[1] = osd_r ^ q.polarity[osd_ctrl_pkg::POL_COLOUR_BIT];
      osd_sig[2] = osd_g ^ q.polarity[osd_ctrl_pkg::POL_COLOUR_BIT];
      osd_sig[3] = osd_b ^ q.polarity[osd_ctrl_pkg::POL_COLOUR_BIT];
      osd_sig[4] = shared;

      // Pin routing between display signals and port values
      d.pins[0] = q.port_select[osd_ctrl_pkg::PSEL_INTENSITY_BIT] ? port_value_in[0]
         : osd_sig[0];
      for (int p = 1; p < 5; p++) begin
         d.pins[p] = q.port_select[osd_ctrl_pkg::PSEL_COLOUR_LSB + p - 1] ? port_value_in[p]
            : osd_sig[p];
      end
   end

   // State register
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
         q.port_select <= osd_ctrl_pkg::RST_PORT_SELECT;
         q.polarity <= osd_ctrl_pkg::RST_BYTE;
         q.misc <= osd_ctrl_pkg::RST_BYTE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign rdata_out = q.rdata;
   assign intensity_pin_out = q.pins[0];
   assign r_pin_out = q.pins[1];
   assign g_pin_out = q.pins[2];
   assign b_pin_out = q.pins[3];
   assign key_blank_output_out = q.pins[4];
   assign osd_tick_out = q.osc_tick;
   assign code_start_out = q.code_start;
   assign line_active_out = q.in_line;
   assign line_index_out = q.line_idx;
   assign line_size_out = q.cur_size;
   assign line_row_out = q.row;
   assign transfer_pulse_out = q.transfer_pulse;
endmodule : osd_output_position_ctrl

// ==== verification/osd_sync_source.sv ====
// Sync source of the signal processor: HD every line, VD once a frame.
// Assumes the clock of the OSD block; each pulse is a level held 8 clocks.
`timescale 1ns/10ps
module osd_sync_source #(parameter int HPER = 120, parameter int VLINES = 48) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Sync pulses
   output logic hd_out,
   output logic vd_out
);
   int hc;
   int vc;
   // Line and frame counters
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         hc <= 0;
         vc <= 0;
      end else begin
         hc <= (hc == HPER - 1) ? 0 : hc + 1;
         if (hc == HPER - 1) begin
            vc <= (vc == VLINES - 1) ? 0 : vc + 1;
         end
      end
   end
   // VD kept away from the HD edge
   assign hd_out = !rst_in && hc < 8;
   assign vd_out = !rst_in && vc == 0 && hc >= 60 && hc < 68;
endmodule : osd_sync_source

// ==== verification/osd_output_position_ctrl_sva.sv ====
// Assertion checker for the OSD output and position control block.
// Assumes it sees only the top module's ports through the bind below.
`timescale 1ns/10ps
module osd_ctrl_chk (
   // Clock, reset and register port
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [osd_ctrl_pkg::ADDR_W-1:0] addr_in,
   input wire logic [osd_ctrl_pkg::DATA_W-1:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [osd_ctrl_pkg::DATA_W-1:0] rdata_out,
   // Sync, port values and outputs
   input wire logic horizontal_pulse_in,
   input wire logic [4:0] port_value_in,
   input wire logic intensity_pin_out,
   input wire logic r_pin_out,
   input wire logic line_active_out,
   input wire logic code_start_out,
   input wire logic transfer_pulse_out
);
   logic hd_q;
   logic pend_q;
   logic set_q;
   logic [7:0] psel_q;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // Previous HD level, pending request and port select mirror
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         hd_q <= 1'b0;
         pend_q <= 1'b0;
         set_q <= 1'b0;
         psel_q <= 8'hf8;
      end else begin
         hd_q <= horizontal_pulse_in;
         set_q <= write_in && addr_in == osd_ctrl_pkg::OFS_CONTROL && wdata_in[0];
         // A request set on the transfer edge itself survives the transfer
         if (write_in && addr_in == osd_ctrl_pkg::OFS_CONTROL && wdata_in[0]) begin
            pend_q <= 1'b1;
         end else if (transfer_pulse_out && !set_q) begin
            pend_q <= 1'b0;
         end
         if (write_in && addr_in == osd_ctrl_pkg::OFS_PORT_SELECT) begin
            psel_q <= wdata_in[7:0];
         end
      end
   end
   sequence hd_rise_s;
      horizontal_pulse_in && !hd_q;
   endsequence
   chk_rdata_idle: assert property (!$past(read_in) |-> rdata_out == '0)
      else $error("read data outside its cycle");
   chk_pulse_hd: assert property (transfer_pulse_out |-> $past(horizontal_pulse_in) && !$past(hd_q))
      else $error("transfer pulse not after an HD rise");
   chk_pulse_pend: assert property (transfer_pulse_out |-> pend_q)
      else $error("transfer pulse without a pending request");
   chk_pulse_single: assert property (transfer_pulse_out |=> !transfer_pulse_out)
      else $error("transfer pulse longer than one cycle");
   chk_idle_move: assert property (pend_q && !line_active_out ##0 hd_rise_s |=> transfer_pulse_out)
      else $error("transfer missed on an idle HD rise");
   chk_red_route: assert property ($past(psel_q[4]) |-> r_pin_out == $past(port_value_in[1]))
      else $error("red pin does not follow the port value");
   chk_int_route: assert property ($past(psel_q[3]) |-> intensity_pin_out == $past(port_value_in[0]))
      else $error("intensity pin does not follow the port value");
   chk_start_line: assert property (code_start_out |-> line_active_out)
      else $error("code start outside a line");
endmodule : osd_ctrl_chk
bind osd_output_position_ctrl osd_ctrl_chk u_chk (.clock_in(clock_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
   .rdata_out(rdata_out), .horizontal_pulse_in(horizontal_pulse_in),
   .port_value_in(port_value_in), .intensity_pin_out(intensity_pin_out),
   .r_pin_out(r_pin_out), .line_active_out(line_active_out),
   .code_start_out(code_start_out), .transfer_pulse_out(transfer_pulse_out));

// ==== verification/tb_osd_output_and_position_control.sv ====
// Self-checking bench for the OSD output and position control block.
// Assumes the sync source model and the bound assertion checker.
`timescale 1ns/10ps
module tb_osd_output_and_position_control;
   localparam int HPER = 120;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic write_in = 1'b0;
   logic read_in = 1'b0;
   logic [7:0] dots = 8'h00;
   logic [4:0] port_value_in = 5'h00;
   logic [15:0] rdata_out;
   logic [15:0] d;
   logic [4:0] pins;
   logic [3:0] lidx;
   logic [1:0] lsize;
   logic hd, vd, cstart, lact, xfer;
   int n_fail = 0;
   int tests_run = 0;
   int len, cs;
   // Clock
   always #20 clock_in = ~clock_in;
   osd_sync_source src (.clock_in(clock_in), .rst_in(rst_in), .hd_out(hd), .vd_out(vd));
   osd_output_position_ctrl dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
      .horizontal_pulse_in(hd), .vertical_pulse_in(vd), .char_dot_in(dots[0]),
      .fringe_dot_in(dots[1]), .char_cell_in(dots[2]), .blank_code_in(dots[3]),
      .code_r_in(dots[4]), .code_g_in(dots[5]), .code_b_in(dots[6]), .code_i_in(dots[7]),
      .port_value_in(port_value_in), .intensity_pin_out(pins[0]), .r_pin_out(pins[1]),
      .g_pin_out(pins[2]), .b_pin_out(pins[3]), .key_blank_output_out(pins[4]),
      .osd_tick_out(), .code_start_out(cstart), .line_active_out(lact),
      .line_index_out(lidx), .line_size_out(lsize), .line_row_out(),
      .transfer_pulse_out(xfer));
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (e !== g) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic guard(input int k);
      if (k >= 20000) begin
         chk("wait bound", 16'h0000, 16'h0001);
         summarize();
      end
   endtask : guard
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= v;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd
   task automatic pinchk(input logic [4:0] e);
      repeat (2) @(posedge clock_in);
      #1 chk("pins", {11'h000, e}, {11'h000, pins});
   endtask : pinchk
   // Waits for a full line, first for VD if asked; length and code start offset
   task automatic meas(input bit frame);
      int k;
      for (k = 0; k < 20000 && frame && vd !== 1'b1; k++) @(negedge clock_in);
      guard(k);
      for (k = 0; k < 20000 && lact !== 1'b1; k++) @(negedge clock_in);
      guard(k);
      len = 0;
      cs = 0;
      for (k = 0; k < 20000 && lact === 1'b1; k++) begin
         if (cstart === 1'b1 && cs == 0) begin
            cs = len;
         end
         len++;
         @(negedge clock_in);
      end
      guard(k);
   endtask : meas
   task automatic t_pins();
      for (int i = 0; i < 4; i++) begin
         rd((i == 3) ? 8'h3f : 8'(i));
         chk("reset value", (i == 0) ? 16'h00f8 : 16'h0000, d);
      end
      port_value_in <= 5'h1e;
      pinchk(5'h1e);
      wr(8'h00, 16'h0008);
      port_value_in <= 5'h01;
      pinchk(5'h01);
      wr(8'h01, 16'h000f);
      pinchk(5'h1f);
      wr(8'h00, 16'h0004);
      wr(8'h02, 16'h0020);
      pinchk(5'h0f);
      wr(8'h01, 16'h0007);
      pinchk(5'h1f);
      // Plane level setup, raster and intensity function off: port path on intensity pin, levels set
      wr(8'h00, 16'h0008);
      wr(8'h02, 16'h0007);
      port_value_in <= 5'h00;
      pinchk(5'h1e);
      $display("pin routing test done");
   endtask : t_pins
   task automatic t_xfer();
      int k;
      wr(8'h02, 16'h0000);
      wr(8'h03, 16'h0001);
      rd(8'h03);
      chk("pending", 16'h0001, {15'h0000, d[0]});
      wr(8'h04, 16'h0005);
      wr(8'h10, 16'h000c);
      wr(8'h11, 16'h000c);
      wr(8'h12, 16'h0001);
      wr(8'h30, 16'h000b);
      for (k = 0; k < 20000 && xfer !== 1'b1; k++) @(negedge clock_in);
      guard(k);
      rd(8'h03);
      chk("pending", 16'h0000, {15'h0000, d[0]});
      $display("transfer test done");
   endtask : t_xfer
   task automatic t_line();
      dots <= 8'hff;
      meas(1'b1);
      chk("off line index", 16'h0002, {12'h000, lidx});
      chk("off line size", 16'h0000, {14'h0000, lsize});
      chk("off line height", 16'h0001, 16'(len / HPER == 9));
      meas(1'b0);
      chk("line index", 16'h0000, {12'h000, lidx});
      chk("line size", 16'h0003, {14'h0000, lsize});
      chk("line height", 16'h0001, 16'(len / HPER == 9));
      chk("code start", 16'h0001, 16'(cs >= (5 * 2 + 20) * 3 - 6 && cs <= 96));
      wr(8'h02, 16'h0080);
      meas(1'b1);
      chk("off double height", 16'h0001, 16'(len / HPER == 18));
      meas(1'b0);
      chk("double height", 16'h0001, 16'(len / HPER == 18));
      $display("line position test done");
   endtask : t_line
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      t_pins();
      t_xfer();
      t_line();
      summarize();
   end
endmodule : tb_osd_output_and_position_control
